// File: sfc_consts.svh
// Function
// RL1: opcode takes two clocks in quad mode, eight clocks in single-bit mode.
// RL2: address, dummy, mode and data bytes take two clocks quad, eight single-bit.
// RL3: soft reset is reset-arm 66H in one frame, then 99H in a later frame.
// RL4: reset acts only right after reset-arm; any other command cancels the arm.
// RL5: no-operation only cancels a pending reset-arm.
// RL6: soft reset selects single-bit mode, burst 8 bytes, clears quad-enable bit; the code keeps no burst setting to restore.
// RL7: soft reset during program or erase aborts it, data may be corrupted.
// RL8: recovery after reset depends on the aborted operation; writes need longer.
// RL9: basic read 03H only in single-bit mode, clock at most 40 MHz.
// RL10: basic read sends opcode and 24-bit address, no dummy, chip select held low.
// RL11: basic read streams from start address, wrapping from top address to zero.
// RL12: streaming read runs until chip select rises.
// RL13: enter_quad_cmd 38H switches all later transfers to four-bit mode.
// RL14: quad_exit_cmd FFH returns to single-bit mode, sent as 8 or 2 clocks.
// RL15: in mode-continuation, first quad exit only restores opcodes; second exits quad.
// RL16: quad exit in single-bit mode: upper_io_lines ignored but driven valid.
// RL17: quad-output read and quad program use two-clock data, need quad_enable_cfg_bit.
// RL18: dual-output data takes four clocks; dual-io address, mode and data four clocks.
// RL19: device ignores address bits above its density.
// RL20: sector erase uses address bits down to 12; lower bits driven valid.
// RL21: block erase decodes to bit 16, 15 or 13 by block size.
// RL22: quad bytes travel as two nibbles, most significant nibble first.
// RL23: single-bit mode samples on rising clock, drives on falling, idle low or high.
`ifndef SFC_CONSTS_SVH
`define SFC_CONSTS_SVH

// ==========================================================================
// timing
`define SFC_CLK_NS 100
`define SFC_SCK_HALF_NS 800
`define SFC_CS_HIGH_NS 200
`define SFC_RCV_SHORT_NS 100000
`define SFC_RCV_LONG_NS 1000000

// ==========================================================================
// opcodes
`define SFC_OPC_RDSR 8'h05
`define SFC_OPC_RESET_ARM 8'h66
`define SFC_OPC_RESET 8'h99
`define SFC_OPC_ENTER_QUAD 8'h38
`define SFC_OPC_QUAD_EXIT 8'hff
`define SFC_OPC_READ 8'h03
`define SFC_OPC_HS_READ 8'h0b
`define SFC_OPC_QOUT_READ 8'h6b
`define SFC_OPC_QIO_READ 8'heb
`define SFC_OPC_DOUT_READ 8'h3b
`define SFC_OPC_DIO_READ 8'hbb
`define SFC_OPC_QPP 8'h32
`define SFC_OPC_PP 8'h02
`define SFC_OPC_SECTOR_ERASE 8'h20
`define SFC_OPC_BLOCK_ERASE 8'hd8
`define SFC_OPC_CHIP_ERASE 8'hc7
`define SFC_CONT_NIB 4'ha
`define SFC_READ_ADR_BYTES 2'h3

// ==========================================================================
// lanes and clocks per byte
`define SFC_LN_X1 3'h1
`define SFC_LN_X2 3'h2
`define SFC_LN_X4 3'h4
`define SFC_CLK_X1 4'h8
`define SFC_CLK_X2 4'h4
`define SFC_CLK_X4 4'h2

// ==========================================================================
// registers
`define SFC_REG_CTRL 8'h00
`define SFC_REG_ADDR 8'h04
`define SFC_REG_LEN 8'h08
`define SFC_REG_DATA 8'h0c
`define SFC_REG_STAT 8'h10
`define SFC_CTRL_START 8
`define SFC_CTRL_STOP 9
`define SFC_CTRL_STREAM 10
`define SFC_CTRL_WR 11
`define SFC_CTRL_QE_SET 12
`define SFC_CTRL_QE_CLR 13
`define SFC_LEN_ADR_LSB 16
`define SFC_LEN_DUM_LSB 18

`endif

// File: sfc_pkg.sv
`default_nettype none
package sfc_pkg;

  typedef enum logic [2:0] {ST_IDLE, ST_SHIFT, ST_NEXT, ST_GAP, ST_RECOVER} sfc_state_t;
  typedef enum logic [2:0] {PH_OPC, PH_ADR, PH_DUM, PH_DAT, PH_END} sfc_phase_t;

endpackage : sfc_pkg
`default_nettype wire

// File: sfc_sync.sv
`default_nettype none
module sfc_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] d_i,
  output logic [3:0] q_o
);

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] q;
  } sfc_sync_t;

  sfc_sync_t st_ff, nxt_st;

  // a bit changes only once the second and third stages agree
  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = d_i;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    nxt_st.q = (st_ff.s2 & ~(st_ff.s2 ^ st_ff.s3)) | (st_ff.q & (st_ff.s2 ^ st_ff.s3));
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q_o = st_ff.q;

endmodule : sfc_sync
`default_nettype wire

// File: sfc_host.sv
`include "sfc_consts.svh"
`default_nettype none
module sfc_host
  import sfc_pkg::*;
#(
  parameter int RCV_SHORT_CYC = (`SFC_RCV_SHORT_NS + `SFC_CLK_NS - 1) / `SFC_CLK_NS,
  parameter int RCV_LONG_CYC = (`SFC_RCV_LONG_NS + `SFC_CLK_NS - 1) / `SFC_CLK_NS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic flash_cs_n_o,
  output logic flash_sck_o,
  input wire logic [3:0] sio_i,
  output logic [3:0] sio_o,
  output logic [3:0] sio_oe_o
);

  // ========================================================================
  // constants and functions
  localparam logic [3:0] HALF = 4'((`SFC_SCK_HALF_NS + `SFC_CLK_NS - 1) / `SFC_CLK_NS);
  localparam logic [1:0] CSH = 2'((`SFC_CS_HIGH_NS + `SFC_CLK_NS - 1) / `SFC_CLK_NS);

  function automatic logic [2:0] sfc_lanes(input sfc_phase_t ph, input logic q, input logic [7:0] op);
    logic [2:0] l;
    l = `SFC_LN_X1;
    if (q) begin
      l = `SFC_LN_X4;
    end else if (ph != PH_OPC) begin
      unique case (op)
        `SFC_OPC_QIO_READ: l = `SFC_LN_X4;
        `SFC_OPC_DIO_READ: l = `SFC_LN_X2;
        `SFC_OPC_QOUT_READ, `SFC_OPC_QPP: l = (ph == PH_DAT) ? `SFC_LN_X4 : `SFC_LN_X1;
        `SFC_OPC_DOUT_READ: l = (ph == PH_DAT) ? `SFC_LN_X2 : `SFC_LN_X1;
        default: l = `SFC_LN_X1;
      endcase
    end
    return l;
  endfunction : sfc_lanes

  function automatic logic [3:0] sfc_clks(input logic [2:0] l);
    return (l == `SFC_LN_X4) ? `SFC_CLK_X4 : (l == `SFC_LN_X2) ? `SFC_CLK_X2 : `SFC_CLK_X1;
  endfunction : sfc_clks

  function automatic sfc_phase_t sfc_next_ph(input sfc_phase_t ph, input logic [1:0] na, input logic [3:0] nd,
                                             input logic hd);
    sfc_phase_t n;
    n = PH_END;
    if (ph == PH_OPC && na != 2'h0) begin
      n = PH_ADR;
    end else if ((ph == PH_OPC || ph == PH_ADR) && nd != 4'h0) begin
      n = PH_DUM;
    end else if (ph != PH_DAT && hd) begin
      n = PH_DAT;
    end
    return n;
  endfunction : sfc_next_ph

  // ========================================================================
  // state
  typedef struct packed {
    sfc_state_t state;
    sfc_phase_t phase;
    logic cs_n;
    logic sck;
    logic [3:0] div;
    logic [3:0] nclk;
    logic [3:0] rises;
    logic [7:0] sh;
    logic [7:0] rx;
    logic [7:0] rxd;
    logic rxv;
    logic [7:0] txd;
    logic txv;
    logic [15:0] cnt;
    logic [7:0] opc;
    logic [23:0] addr;
    logic [7:0] mode;
    logic [15:0] len;
    logic [1:0] nadr;
    logic [3:0] ndum;
    logic stream;
    logic wr;
    logic stop;
    logic qe;
    logic quad;
    logic cont;
    logic arm;
    logic refused;
    logic wbusy;
    logic [1:0] gap;
    logic [19:0] rcv;
    logic ack;
    logic [31:0] dat;
  } sfc_host_t;

  sfc_host_t st_ff, nxt_st;
  logic [3:0] sin;
  logic acc, wr_go, rd_go, more, bad, fend;
  logic [2:0] ln;
  logic [7:0] nb, op_new;
  logic [15:0] cnt;
  logic [23:0] adr;
  sfc_phase_t ph;

  sfc_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(sio_i),
    .q_o(sin)
  );

  // ========================================================================
  // next state
  always_comb begin
    nxt_st = st_ff;
    acc = wb_cyc_i & wb_stb_i;
    wr_go = acc & wb_we_i & st_ff.ack & (wb_sel_i == 4'hf);
    rd_go = acc & ~wb_we_i & st_ff.ack;
    op_new = wb_dat_i[7:0];
    ln = sfc_lanes(st_ff.phase, st_ff.quad, st_ff.opc);
    adr = (st_ff.opc == `SFC_OPC_SECTOR_ERASE) ? {st_ff.addr[23:12], 12'h000} : st_ff.addr; // [RL20]
    more = (st_ff.cnt > 16'h0001) || (st_ff.phase == PH_DAT && st_ff.stream);
    ph = more ? st_ff.phase : sfc_next_ph(st_ff.phase, st_ff.nadr, st_ff.ndum,
                                          st_ff.len != 16'h0000 || st_ff.stream);
    if (more) begin
      cnt = st_ff.stream && st_ff.phase == PH_DAT ? st_ff.cnt : st_ff.cnt - 16'h0001;
    end else if (ph == PH_ADR) begin
      cnt = {14'h0000, st_ff.nadr};
    end else if (ph == PH_DUM) begin
      cnt = {12'h000, st_ff.ndum};
    end else begin
      cnt = st_ff.stream ? 16'h0001 : st_ff.len;
    end
    if (ph == PH_ADR) begin
      nb = (cnt == 16'h0003) ? adr[23:16] : (cnt == 16'h0002) ? adr[15:8] : adr[7:0];
    end else if (ph == PH_DUM) begin
      nb = (cnt == {12'h000, st_ff.ndum}) ? st_ff.mode : 8'h00;
    end else begin
      nb = (ph == PH_DAT && st_ff.wr) ? st_ff.txd : 8'h00;
    end
    // quad-only data opcodes need the quad-enable bit outside quad mode, basic read is single-bit only
    bad = (st_ff.state != ST_IDLE) ||
          (op_new == `SFC_OPC_READ && (st_ff.quad || st_ff.ndum != 4'h0 ||
                                      st_ff.nadr != `SFC_READ_ADR_BYTES)) || // [RL9] [RL10]
          ((op_new == `SFC_OPC_QOUT_READ || op_new == `SFC_OPC_QPP || op_new == `SFC_OPC_QIO_READ) &&
           ~st_ff.quad && ~st_ff.qe) || // [RL17]
          (op_new == `SFC_OPC_ENTER_QUAD && st_ff.quad);
    fend = 1'b0;

    // read of the data register frees the receive byte before the link may refill it
    if (rd_go && wb_adr_i == `SFC_REG_DATA) begin
      nxt_st.rxv = 1'b0;
    end

    unique case (st_ff.state)
      ST_IDLE: begin
        nxt_st.cs_n = 1'b1;
      end
      ST_SHIFT: begin
        if (st_ff.div == HALF - 4'h1) begin
          nxt_st.div = 4'h0;
          if (!st_ff.sck) begin
            nxt_st.sck = 1'b1; // [RL23]
            nxt_st.nclk = st_ff.nclk - 4'h1;
            nxt_st.rises = st_ff.rises + 4'h1;
            if (ln == `SFC_LN_X4) begin
              nxt_st.rx = {st_ff.rx[3:0], sin};
            end else if (ln == `SFC_LN_X2) begin
              nxt_st.rx = {st_ff.rx[5:0], sin[1:0]};
            end else begin
              nxt_st.rx = {st_ff.rx[6:0], sin[1]};
            end
          end else begin
            nxt_st.sck = 1'b0; // [RL23]
            if (st_ff.nclk == 4'h0) begin
              nxt_st.state = ST_NEXT;
              if (st_ff.phase == PH_DAT && !st_ff.wr) begin
                nxt_st.rxd = st_ff.rx;
                nxt_st.rxv = 1'b1;
              end
            end else begin
              nxt_st.sh = st_ff.sh << ln; // [RL22]
            end
          end
        end else begin
          nxt_st.div = st_ff.div + 4'h1;
        end
      end
      ST_NEXT: begin
        if (ph == PH_END || (ph == PH_DAT && st_ff.stop)) begin // [RL12]
          fend = 1'b1;
          nxt_st.state = ST_GAP;
          nxt_st.cs_n = 1'b1; // [RL3]
          nxt_st.gap = CSH;
          nxt_st.stop = 1'b0;
          nxt_st.arm = (st_ff.opc == `SFC_OPC_RESET_ARM); // [RL4] [RL5]
          if (st_ff.opc == `SFC_OPC_RESET && st_ff.arm) begin
            nxt_st.quad = 1'b0; // [RL6]
            nxt_st.cont = 1'b0;
            nxt_st.qe = 1'b0;
            nxt_st.wbusy = 1'b0;
            nxt_st.rcv = st_ff.wbusy ? 20'(RCV_LONG_CYC) : 20'(RCV_SHORT_CYC); // [RL8]
          end
          if (st_ff.opc == `SFC_OPC_ENTER_QUAD) begin
            nxt_st.quad = 1'b1; // [RL13]
          end
          if (st_ff.opc == `SFC_OPC_QUAD_EXIT) begin
            if (st_ff.cont) begin
              nxt_st.cont = 1'b0; // [RL15]
            end else begin
              nxt_st.quad = 1'b0; // [RL14]
            end
          end
          if ((st_ff.opc == `SFC_OPC_HS_READ || st_ff.opc == `SFC_OPC_QIO_READ) && st_ff.ndum != 4'h0) begin
            nxt_st.cont = (st_ff.mode[7:4] == `SFC_CONT_NIB);
          end
          if (st_ff.opc == `SFC_OPC_PP || st_ff.opc == `SFC_OPC_QPP || st_ff.opc == `SFC_OPC_SECTOR_ERASE ||
              st_ff.opc == `SFC_OPC_BLOCK_ERASE || st_ff.opc == `SFC_OPC_CHIP_ERASE) begin
            nxt_st.wbusy = 1'b1;
          end else if (st_ff.opc == `SFC_OPC_RDSR) begin
            nxt_st.wbusy = 1'b0;
          end
        end else if (!(ph == PH_DAT && (st_ff.wr ? !st_ff.txv : st_ff.rxv))) begin
          // clock stays low while software owes a byte or has not taken one
          nxt_st.phase = ph;
          nxt_st.cnt = cnt;
          nxt_st.sh = nb;
          nxt_st.nclk = sfc_clks(sfc_lanes(ph, st_ff.quad, st_ff.opc)); // [RL1] [RL2] [RL17] [RL18]
          nxt_st.rises = 4'h0;
          nxt_st.div = 4'h0;
          nxt_st.state = ST_SHIFT;
          if (ph == PH_DAT && st_ff.wr) begin
            nxt_st.txv = 1'b0;
          end
        end
      end
      ST_GAP: begin
        nxt_st.gap = st_ff.gap - 2'h1;
        if (st_ff.gap <= 2'h1) begin
          nxt_st.state = (st_ff.rcv != 20'h00000) ? ST_RECOVER : ST_IDLE;
        end
      end
      ST_RECOVER: begin
        nxt_st.rcv = st_ff.rcv - 20'h00001; // [RL8]
        if (st_ff.rcv <= 20'h00001) begin
          nxt_st.state = ST_IDLE;
        end
      end
    endcase

    // ======================================================================
    // register bus
    nxt_st.ack = acc & ~st_ff.ack;
    if (acc & ~st_ff.ack & ~wb_we_i) begin
      case (wb_adr_i)
        `SFC_REG_CTRL: nxt_st.dat = {18'h00000, st_ff.wr, st_ff.stream, 4'h0, st_ff.opc};
        `SFC_REG_ADDR: nxt_st.dat = {st_ff.mode, st_ff.addr};
        `SFC_REG_LEN: nxt_st.dat = {10'h000, st_ff.ndum, st_ff.nadr, st_ff.len};
        `SFC_REG_DATA: nxt_st.dat = {24'h000000, st_ff.rxd};
        `SFC_REG_STAT: nxt_st.dat = {23'h000000, st_ff.wbusy, st_ff.refused, st_ff.txv, st_ff.rxv,
                                     st_ff.qe, st_ff.arm, st_ff.cont, st_ff.quad, st_ff.state != ST_IDLE};
        default: nxt_st.dat = 32'h00000000;
      endcase
    end
    if (wr_go) begin
      unique case (wb_adr_i)
        `SFC_REG_ADDR: begin
          nxt_st.addr = wb_dat_i[23:0];
          nxt_st.mode = wb_dat_i[31:24];
        end
        `SFC_REG_LEN: begin
          nxt_st.len = wb_dat_i[15:0];
          nxt_st.nadr = wb_dat_i[`SFC_LEN_ADR_LSB +: 2];
          nxt_st.ndum = wb_dat_i[`SFC_LEN_DUM_LSB +: 4];
        end
        `SFC_REG_DATA: begin
          nxt_st.txd = wb_dat_i[7:0];
          nxt_st.txv = 1'b1;
        end
        `SFC_REG_CTRL: begin
          if (wb_dat_i[`SFC_CTRL_STOP]) begin
            nxt_st.stop = 1'b1;
          end
          if (wb_dat_i[`SFC_CTRL_QE_SET]) begin
            nxt_st.qe = 1'b1;
          end
          if (wb_dat_i[`SFC_CTRL_QE_CLR]) begin
            nxt_st.qe = 1'b0;
          end
          if (wb_dat_i[`SFC_CTRL_START] && bad) begin
            nxt_st.refused = 1'b1; // [RL9]
          end else if (wb_dat_i[`SFC_CTRL_START]) begin
            nxt_st.opc = op_new;
            nxt_st.stream = wb_dat_i[`SFC_CTRL_STREAM];
            nxt_st.wr = wb_dat_i[`SFC_CTRL_WR];
            nxt_st.stop = 1'b0;
            nxt_st.refused = 1'b0;
            nxt_st.cs_n = 1'b0;
            nxt_st.sck = 1'b0;
            nxt_st.div = 4'h0;
            nxt_st.rises = 4'h0;
            nxt_st.phase = PH_OPC;
            nxt_st.cnt = 16'h0001;
            nxt_st.sh = op_new;
            nxt_st.nclk = sfc_clks(sfc_lanes(PH_OPC, st_ff.quad, op_new)); // [RL1]
            // continuation frames carry no opcode, only quad exit breaks out
            nxt_st.state = (st_ff.cont && op_new != `SFC_OPC_QUAD_EXIT) ? ST_NEXT : ST_SHIFT; // [RL15]
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
      st_ff.cs_n <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ========================================================================
  // pins
  always_comb begin
    sio_o = 4'h0;
    sio_oe_o = 4'h0;
    if (!st_ff.quad && ln != `SFC_LN_X4) begin
      sio_o[3:2] = 2'b11; // [RL16]
      sio_oe_o[3:2] = 2'b11;
    end
    if (!st_ff.cs_n && !(st_ff.phase == PH_DAT && !st_ff.wr)) begin
      if (ln == `SFC_LN_X4) begin
        sio_o = st_ff.sh[7:4]; // [RL22]
        sio_oe_o = 4'hf;
      end else if (ln == `SFC_LN_X2) begin
        sio_o[1:0] = st_ff.sh[7:6];
        sio_oe_o[1:0] = 2'b11;
      end else begin
        sio_o[0] = st_ff.sh[7];
        sio_oe_o[0] = 1'b1;
        if (st_ff.opc == `SFC_OPC_QUAD_EXIT) begin
          sio_o[1] = 1'b1; // [RL16]
          sio_oe_o[1] = 1'b1;
        end
      end
    end
  end

  assign flash_cs_n_o = st_ff.cs_n;
  assign flash_sck_o = st_ff.sck;
  assign wb_ack_o = st_ff.ack;
  assign wb_dat_o = st_ff.dat;

  // ========================================================================
  // checks
  a_byte_clocks: assert property ( // [RL1] [RL2]
    @(posedge clk_i) disable iff (rst_i)
    (st_ff.state == ST_SHIFT && st_ff.sck && st_ff.div == HALF - 4'h1 && st_ff.nclk == 4'h0)
      |-> st_ff.rises == sfc_clks(ln))
    else $error("wrong clock count per byte");
  a_read_refused: assert property ( // [RL9]
    @(posedge clk_i) disable iff (rst_i)
    (wr_go && wb_adr_i == `SFC_REG_CTRL && wb_dat_i[`SFC_CTRL_START] && op_new == `SFC_OPC_READ && st_ff.quad)
      |=> st_ff.refused && st_ff.cs_n)
    else $error("basic read started in quad mode");
  a_arm_cancel: assert property ( // [RL4]
    @(posedge clk_i) disable iff (rst_i)
    (fend && st_ff.opc != `SFC_OPC_RESET_ARM) |=> !st_ff.arm)
    else $error("reset arm survived another command");
  a_soft_reset: assert property ( // [RL6]
    @(posedge clk_i) disable iff (rst_i)
    (fend && st_ff.opc == `SFC_OPC_RESET && st_ff.arm) |=> !st_ff.quad && !st_ff.qe && !st_ff.cont)
    else $error("soft reset left quad state");
  a_reset_recover: assert property ( // [RL8]
    @(posedge clk_i) disable iff (rst_i)
    (fend && st_ff.opc == `SFC_OPC_RESET && st_ff.arm) |-> ##[1:8] st_ff.state == ST_RECOVER)
    else $error("no recovery wait after reset");
  a_quad_enter: assert property ( // [RL13]
    @(posedge clk_i) disable iff (rst_i)
    (fend && st_ff.opc == `SFC_OPC_ENTER_QUAD) |=> st_ff.quad ##1 st_ff.quad)
    else $error("quad mode not entered");
  a_exit_two_step: assert property ( // [RL15]
    @(posedge clk_i) disable iff (rst_i)
    (fend && st_ff.opc == `SFC_OPC_QUAD_EXIT && st_ff.cont) |=> st_ff.quad == $past(st_ff.quad) && !st_ff.cont)
    else $error("first quad exit left quad mode");
  a_upper_valid: assert property ( // [RL16]
    @(posedge clk_i) disable iff (rst_i)
    (!st_ff.quad && !flash_cs_n_o && ln == `SFC_LN_X1) |-> sio_oe_o[3:2] == 2'b11 && sio_o[3:2] == 2'b11)
    else $error("upper lines floating in single-bit mode");
  a_sck_idle: assert property ( // [RL23]
    @(posedge clk_i) disable iff (rst_i)
    flash_cs_n_o |-> !flash_sck_o)
    else $error("serial clock high outside a frame");
  a_wb_ack: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (acc && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not a single cycle");

endmodule : sfc_host
`default_nettype wire

// File: sfc_flash_model.sv
`default_nettype none
module sfc_flash_model (
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic [3:0] sio_o_i,
  input wire logic [3:0] sio_oe_i,
  output logic [3:0] sio_line_o,
  output logic quad_o,
  output logic [7:0] clks_o,
  output logic [3:0] resets_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic arm = 1'b0;
  logic rd = 1'b0;
  logic cont = 1'b0;
  logic [7:0] mb = 8'h00;
  logic [3:0] drv = 4'h0;
  logic [7:0] sh = 8'h00;
  logic [7:0] opc = 8'h00;
  logic [7:0] ob = 8'h00;
  logic [23:0] adr = 24'h000000;
  int nb = 0;
  int bits = 0;
  int obit = 0;
  // ==========================================
  // lines and frame decode
  // undriven lines flip on release, so stale data never reads as good
  assign sio_line_o = (sio_oe_i & sio_o_i) | (~sio_oe_i & drv);
  initial begin
    quad_o = 1'b0;
    clks_o = 8'h00;
    resets_o = 4'h0;
  end
  always @(negedge cs_n_i) begin
    nb = 0;
    bits = 0;
    rd = 1'b0;
    clks_o = 8'h00;
  end
  always @(posedge cs_n_i) begin
    drv = ~drv;
    if (nb > 0) begin
      if (opc == 8'h66) arm = 1'b1;
      else begin
        if (opc == 8'h99 && arm) begin
          quad_o = 1'b0;
          cont = 1'b0;
          resets_o = resets_o + 4'h1;
        end
        if (opc == 8'h38) quad_o = 1'b1;
        // a mode byte of ax sets cont, so the next quad exit only clears it
        if (opc == 8'h0b && quad_o && nb > 4) cont = (mb[7:4] == 4'ha);
        if (opc == 8'hff) begin
          if (cont) cont = 1'b0;
          else quad_o = 1'b0;
        end
        arm = 1'b0;
      end
    end
  end
  // ==========================================
  // shifting
  always @(posedge sck_i) begin
    if (!cs_n_i) begin
      clks_o = clks_o + 8'h01;
      if (quad_o) sh = {sh[3:0], sio_line_o};
      else sh = {sh[6:0], sio_line_o[0]};
      bits = bits + (quad_o ? 4 : 1);
      if (bits == 8) begin
        bits = 0;
        if (nb == 0) opc = sh;
        else if (nb < 4) adr = {adr[15:0], sh};
        else if (nb == 4) mb = sh;
        nb = nb + 1;
        if (nb == 4 && opc == 8'h03 && !quad_o) begin
          rd = 1'b1;
          obit = 0;
          ob = adr[7:0] + adr[23:16];
        end
      end
    end
  end
  always @(negedge sck_i) begin
    if (rd) begin
      drv[1] = ob[7];
      ob = {ob[6:0], 1'b0};
      obit = obit + 1;
      if (obit == 8) begin
        obit = 0;
        adr = adr + 24'h000001;
        ob = adr[7:0] + adr[23:16];
      end
    end
  end
endmodule : sfc_flash_model
`default_nettype wire

// File: testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, rd;
  logic wb_ack_o, cs_n, sck, dev_quad;
  logic [3:0] sio_i, sio_o, sio_oe;
  logic [7:0] dev_clks;
  logic [3:0] dev_resets;
  int mismatches = 0;
  int compares = 0;
  always #50 clk_i = ~clk_i;
  // ==========================================
  // instances
  sfc_host #(.RCV_SHORT_CYC(4), .RCV_LONG_CYC(8)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .flash_cs_n_o(cs_n), .flash_sck_o(sck),
    .sio_i(sio_i), .sio_o(sio_o), .sio_oe_o(sio_oe));
  sfc_flash_model dev (
    .cs_n_i(cs_n), .sck_i(sck), .sio_o_i(sio_o), .sio_oe_i(sio_oe), .sio_line_o(sio_i),
    .quad_o(dev_quad), .clks_o(dev_clks), .resets_o(dev_resets));
  // ==========================================
  // tasks
  task automatic finish_test;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // request held until the edge that sees ack; only the watchdog ends a hang
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= 4'hf;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    do begin
      wb(1'b0, 8'h10, 32'h0);
      n++;
    end while (rd[b] !== v && n < 500);
    if (rd[b] !== v) begin
      mismatches++;
      $display("Error at %0t: status poll timed out", $time);
    end
  endtask : poll
  task automatic cmd(input logic [7:0] opc);
    wb(1'b1, 8'h00, {23'h0, 1'b1, opc});
    poll(0, 1'b0);
  endtask : cmd
  // ==========================================
  // scenarios
  task automatic t_arm;
    cmd(8'h66);
    check(rd[3], 1'b1);
    check(dev_clks, 8'h08);
    cmd(8'h00);
    check(rd[3], 1'b0);
    cmd(8'h99);
    check(dev_resets, 4'h0);
  endtask : t_arm
  task automatic t_quad;
    cmd(8'h38);
    check(rd[1], 1'b1);
    check(dev_quad, 1'b1);
    cmd(8'h03);
    check(rd[7], 1'b1);
    cmd(8'h66);
    check(dev_clks, 8'h02);
    cmd(8'h99);
    check(rd[1], 1'b0);
    check(dev_quad, 1'b0);
    check(dev_resets, 4'h1);
  endtask : t_quad
  task automatic t_exit;
    cmd(8'h38);
    cmd(8'hff);
    check(dev_clks, 8'h02);
    check(rd[1], 1'b0);
    check(dev_quad, 1'b0);
    cmd(8'hff);
    check(dev_clks, 8'h08);
  endtask : t_exit
  // top address first, so the second byte only matches after a wrap
  task automatic t_read;
    wb(1'b1, 8'h04, 32'h00ffffff);
    wb(1'b1, 8'h08, 32'h00030002);
    wb(1'b1, 8'h00, 32'h00000103);
    for (int i = 0; i < 2; i++) begin
      poll(5, 1'b1);
      wb(1'b0, 8'h0c, 32'h0);
      check(rd[7:0], (i == 0) ? 8'hfe : 8'h00);
    end
    poll(0, 1'b0);
    check(dev_clks, 8'h30);
  endtask : t_read
  task automatic t_erase;
    wb(1'b1, 8'h08, 32'h00030000);
    wb(1'b1, 8'h04, 32'h00123456);
    cmd(8'h20);
    check(dev.adr, 24'h123000);
    cmd(8'hd8);
    check(dev.adr, 24'h123456);
  endtask : t_erase
  // mode byte a0 leaves the read in continuation, so quad exit takes two frames
  task automatic t_cont;
    wb(1'b1, 8'h08, 32'h0);
    cmd(8'h38);
    wb(1'b1, 8'h04, 32'ha0000000);
    wb(1'b1, 8'h08, 32'h000f0001);
    cmd(8'h0b);
    check(rd[2], 1'b1);
    check(dev_clks, 8'h10);
    wb(1'b0, 8'h0c, 32'h0);
    wb(1'b1, 8'h08, 32'h0);
    cmd(8'hff);
    check(rd[2], 1'b0);
    check(rd[1], 1'b1);
    check(dev_quad, 1'b1);
    cmd(8'hff);
    check(rd[1], 1'b0);
    check(dev_quad, 1'b0);
  endtask : t_cont
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, 8'h10, 32'h0);
    check(rd, 32'h0);
    t_arm;
    t_quad;
    t_exit;
    t_read;
    t_erase;
    t_cont;
    finish_test;
  end
  initial begin
    #3000000;
    mismatches++;
    finish_test;
  end
endmodule : testbench
`default_nettype wire
